/* logic/bse_exec.sv */
`timescale 1ns/1ps
module bse_exec
	import bse_pkg::*;
#(
	parameter int unsigned P_PC_W = PC_W
)
(
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_start,
	input  wire bse_op_e           i_op,
	input  wire logic [P_PC_W-1:0] i_pc,
	input  wire logic [DATA_W-1:0] i_rd_val,
	input  wire logic [DATA_W-1:0] i_rr_val,
	input  wire logic [DATA_W-1:0] i_imm,
	input  wire logic [DATA_W-1:0] i_io_val,
	input  wire logic [SEL_W-1:0]  i_bit_sel,
	input  wire logic [DATA_W-1:0] i_status_flags_reg,
	input  wire logic [OFF_W-1:0]  i_offset,
	input  wire logic [PTR_W-1:0]  i_ptr,
	input  wire logic              i_skip_two,
	output logic                   o_ready,
	output logic                   o_done,
	output logic                   o_reg_we,
	output logic [DATA_W-1:0]      o_reg_data,
	output logic                   o_status_flags_reg_we,
	output logic [DATA_W-1:0]      o_status_flags_reg_data,
	output logic                   o_pc_load,
	output logic [P_PC_W-1:0]      o_next_pc,
	output logic                   o_push_we,
	output logic [P_PC_W-1:0]      o_push_addr
);

	////////////////////////////////////////////////////////////////////
	// Operation class decode

	logic is_or;
	logic is_clr;
	logic is_tst;
	logic is_logic;
	logic is_jmp;
	logic is_call;
	logic is_skip;
	logic is_branch;

	assign is_or     = (i_op == OP_OR_MASK);
	assign is_clr    = (i_op == OP_AND_NOT);
	assign is_tst    = (i_op == OP_SELF_AND);
	assign is_logic  = is_or | is_clr | is_tst;
	assign is_jmp    = (i_op == OP_PTR_JUMP);
	assign is_call   = (i_op == OP_PTR_CALL);
	assign is_skip   = (i_op >= OP_EQ_SKIP) && (i_op <= OP_IOBIT_HIGH);
	assign is_branch = (i_op >= OP_BR_FLAG_HI) && (i_op <= OP_BR_HC_LO);

	////////////////////////////////////////////////////////////////////
	// Bit-mask and test data path

	logic [DATA_W-1:0] or_res;
	logic [DATA_W-1:0] clr_res;
	logic [DATA_W-1:0] tst_res;
	logic [DATA_W-1:0] logic_res;
	logic              res_z;
	logic              res_n;
	logic              res_v;
	logic              res_s;
	logic [DATA_W-1:0] flag_keep;
	logic [DATA_W-1:0] flag_new;
	logic [DATA_W-1:0] status_flags_reg_upd;

	assign or_res  = i_rd_val | i_imm;
	assign clr_res = i_rd_val & (MASK_ALL - i_imm);
	assign tst_res = i_rd_val & i_rd_val;
	assign logic_res = is_or ? or_res : is_clr ? clr_res : tst_res;

	// Logic results always clear overflow, so sign equals negative
	assign res_z = (logic_res == '0);
	assign res_n = logic_res[DATA_W-1];
	assign res_v = 1'b0;
	assign res_s = res_n ^ res_v;

	// Only Z N V S are replaced; C H T I pass through untouched
	assign flag_keep = ~((DATA_W'(1) << FLG_Z) | (DATA_W'(1) << FLG_N)
	                   | (DATA_W'(1) << FLG_V) | (DATA_W'(1) << FLG_S));
	assign flag_new  = (DATA_W'(res_z) << FLG_Z)
	                 | (DATA_W'(res_n) << FLG_N)
	                 | (DATA_W'(res_v) << FLG_V)
	                 | (DATA_W'(res_s) << FLG_S);
	assign status_flags_reg_upd  = (i_status_flags_reg & flag_keep) | flag_new;

	////////////////////////////////////////////////////////////////////
	// Skip and branch conditions

	logic reg_bit;
	logic io_bit;
	logic sel_flag;
	logic n_xor_v;
	logic skip_cond;
	logic br_cond;

	assign reg_bit  = i_rr_val[i_bit_sel];
	assign io_bit   = i_io_val[i_bit_sel];
	// For flag branches the flag number travels on the bit select
	assign sel_flag = i_status_flags_reg[i_bit_sel];
	assign n_xor_v  = i_status_flags_reg[FLG_N] ^ i_status_flags_reg[FLG_V];

	assign skip_cond =
		(i_op == OP_EQ_SKIP    && i_rd_val == i_rr_val) |
		(i_op == OP_RBIT_LOW   && !reg_bit)             |
		(i_op == OP_RBIT_HIGH  &&  reg_bit)             |
		(i_op == OP_IOBIT_LOW  && !io_bit)              |
		(i_op == OP_IOBIT_HIGH &&  io_bit);

	assign br_cond =
		(i_op == OP_BR_FLAG_HI &&  sel_flag)        |
		(i_op == OP_BR_FLAG_LO && !sel_flag)        |
		(i_op == OP_BR_CARRY   &&  i_status_flags_reg[FLG_C])   |
		(i_op == OP_BR_UNEQUAL && !i_status_flags_reg[FLG_Z])   |
		(i_op == OP_BR_MINUS   &&  i_status_flags_reg[FLG_N])   |
		(i_op == OP_BR_PLUS    && !i_status_flags_reg[FLG_N])   |
		(i_op == OP_BR_SGE     && !n_xor_v)         |
		(i_op == OP_BR_SLT     &&  n_xor_v)         |
		(i_op == OP_BR_HC_HI   &&  i_status_flags_reg[FLG_H])   |
		(i_op == OP_BR_HC_LO   && !i_status_flags_reg[FLG_H]);

	////////////////////////////////////////////////////////////////////
	// Program counter targets

	logic [P_PC_W-1:0] pc_inc;
	logic [P_PC_W-1:0] pc_skip;
	logic [P_PC_W-1:0] pc_ptr;
	logic [P_PC_W-1:0] off_ext;
	logic [P_PC_W-1:0] pc_branch;
	logic              redirect;
	logic [P_PC_W-1:0] pc_target;

	assign pc_inc  = i_pc + P_PC_W'(1);
	// A skipped two-word instruction moves the counter one word further
	assign pc_skip = i_pc + (i_skip_two ? P_PC_W'(3) : P_PC_W'(2));
	// Upper counter bits are forced to zero by the zero extension
	assign pc_ptr  = P_PC_W'(i_ptr);
	// Sign extension lets branches reach backward as well as forward
	assign off_ext = {{(P_PC_W-OFF_W){i_offset[OFF_W-1]}}, i_offset};
	assign pc_branch = i_pc + off_ext + P_PC_W'(1);

	assign redirect = is_jmp | is_call
	                | (is_skip & skip_cond)
	                | (is_branch & br_cond);
	assign pc_target = (is_jmp | is_call)      ? pc_ptr    :
	                   (is_branch & br_cond)   ? pc_branch :
	                   (is_skip & skip_cond)   ? pc_skip   : pc_inc;

	////////////////////////////////////////////////////////////////////
	// Cycle cost of the accepted operation

	logic [CNT_W-1:0] call_cyc;
	logic [CNT_W-1:0] skip_cyc;
	logic [CNT_W-1:0] op_cyc;

	// A wide counter needs one more stack beat on a call
	assign call_cyc = (P_PC_W > SHORT_PC_W) ? CYC_FOUR : CYC_THREE;
	assign skip_cyc = !skip_cond ? CYC_ONE   :
	                  i_skip_two ? CYC_THREE : CYC_TWO;
	assign op_cyc   = is_jmp    ? CYC_TWO  :
	                  is_call   ? call_cyc :
	                  is_skip   ? skip_cyc :
	                  (is_branch & br_cond) ? CYC_TWO : CYC_ONE;

	////////////////////////////////////////////////////////////////////
	// Sequencer

	bse_state_e       state_ff;
	bse_state_e       nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             accept;
	logic             last;

	assign last    = (state_ff == ST_BUSY) && (cnt_ff == CNT_W'(1));
	assign o_done  = last;
	// Back-to-back issue: the last cycle of one op takes the next
	assign o_ready = (state_ff == ST_IDLE) | last;
	assign accept  = i_start & o_ready;

	// Next state and remaining-cycle count
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (accept)
				begin
					nxt_state = ST_BUSY;
					nxt_cnt   = op_cyc;
				end
			end
			ST_BUSY:
			begin
				if (accept)
				begin
					nxt_cnt = op_cyc;
				end
				else if (last)
				begin
					nxt_state = ST_IDLE;
					nxt_cnt   = '0;
				end
				else
				begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result registers, loaded when an operation is accepted

	logic              reg_we_ff;
	logic [DATA_W-1:0] reg_data_ff;
	logic              status_flags_reg_we_ff;
	logic [DATA_W-1:0] status_flags_reg_data_ff;
	logic              redirect_ff;
	logic [P_PC_W-1:0] pc_ff;
	logic              call_ff;
	logic [P_PC_W-1:0] ret_ff;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			reg_we_ff    <= 1'b0;
			reg_data_ff  <= '0;
			status_flags_reg_we_ff   <= 1'b0;
			status_flags_reg_data_ff <= '0;
			redirect_ff  <= 1'b0;
			pc_ff        <= '0;
			call_ff      <= 1'b0;
			ret_ff       <= '0;
		end
		else if (accept)
		begin
			reg_we_ff    <= is_or | is_clr;
			reg_data_ff  <= logic_res;
			status_flags_reg_we_ff   <= is_logic;
			status_flags_reg_data_ff <= status_flags_reg_upd;
			redirect_ff  <= redirect;
			pc_ff        <= pc_target;
			call_ff      <= is_call;
			ret_ff       <= pc_inc;
		end
	end

	// Strobes fire only in the final cycle; data stays until next accept
	assign o_reg_we    = last & reg_we_ff;
	assign o_reg_data  = reg_data_ff;
	assign o_status_flags_reg_we   = last & status_flags_reg_we_ff;
	assign o_status_flags_reg_data = status_flags_reg_data_ff;
	assign o_pc_load   = last & redirect_ff;
	assign o_next_pc   = pc_ff;
	assign o_push_we   = last & call_ff;
	assign o_push_addr = ret_ff;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	a_mask_set_res: assert property (
		accept && i_op == OP_OR_MASK |=> o_done && o_reg_we
		&& o_reg_data == ($past(i_rd_val) | $past(i_imm))
		&& o_status_flags_reg_we)
		else $error("mask-set result or timing wrong");
	a_mask_clr_res: assert property (
		accept && i_op == OP_AND_NOT |=> o_reg_we
		&& o_reg_data == ($past(i_rd_val) & ~$past(i_imm)))
		else $error("mask-clear result wrong");
	a_test_flags: assert property (
		accept && i_op == OP_SELF_AND |=> o_done && !o_reg_we
		&& o_status_flags_reg_we
		&& o_status_flags_reg_data[FLG_Z] == ($past(i_rd_val) == '0)
		&& o_status_flags_reg_data[FLG_N] == $past(i_rd_val[DATA_W-1])
		&& !o_status_flags_reg_data[FLG_V])
		else $error("test flags wrong");
	a_ptr_jump_pc: assert property (
		accept && i_op == OP_PTR_JUMP |=> !o_done
		##1 o_done && o_pc_load && !o_status_flags_reg_we
		&& o_next_pc == P_PC_W'($past(i_ptr, 2)))
		else $error("pointer jump wrong");
	a_ptr_call_len: assert property (
		accept && i_op == OP_PTR_CALL |=> !o_done [*2]
		##[1:2] o_done && o_push_we && o_pc_load)
		else $error("pointer call length wrong");
	a_skip_eq_pc: assert property (
		accept && i_op == OP_EQ_SKIP && i_rd_val == i_rr_val
		&& !i_skip_two |=> !o_done ##1 o_done && o_pc_load
		&& o_next_pc == $past(i_pc, 2) + P_PC_W'(2))
		else $error("equal skip wrong");
	a_no_skip_one: assert property (
		accept && i_op == OP_RBIT_LOW && i_rr_val[i_bit_sel]
		|=> o_done && !o_pc_load && !o_status_flags_reg_we)
		else $error("register bit skip taken wrongly");
	a_io_skip_two: assert property (
		accept && i_op == OP_IOBIT_HIGH && i_io_val[i_bit_sel]
		&& i_skip_two |=> !o_done [*2] ##1 o_done
		&& o_next_pc == $past(i_pc, 3) + P_PC_W'(3))
		else $error("I/O bit skip wrong");
	// Signed cast keeps this target independent of the extension logic
	a_branch_back: assert property (
		accept && i_op == OP_BR_UNEQUAL && !i_status_flags_reg[FLG_Z]
		|=> !o_done ##1 o_done && o_pc_load
		&& o_next_pc == $past(i_pc, 2)
		+ P_PC_W'($signed($past(i_offset, 2))) + P_PC_W'(1))
		else $error("relative branch target wrong");
	a_signed_ge: assert property (
		accept && i_op == OP_BR_SGE |=> o_done
		== (($past(i_status_flags_reg[FLG_N]) ^ $past(i_status_flags_reg[FLG_V])) != 1'b0))
		else $error("signed ge decision wrong");
	a_branch_flags: assert property (
		accept && is_branch |=> ##[0:1] o_done && !o_status_flags_reg_we
		&& !o_reg_we)
		else $error("branch touched flags");
	c_skip_two: cover property (accept && is_skip && skip_cond && i_skip_two);
	c_back_branch: cover property (
		accept && is_branch && br_cond && i_offset[OFF_W-1]);
	c_call_done: cover property (o_push_we);
	c_back_to_back: cover property (accept ##1 accept ##1 accept);
endmodule : bse_exec

/* logic/bse_pkg.sv */
package bse_pkg;

	// Data path and counter widths
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned PTR_W   = 16;
	localparam int unsigned PC_W    = 22;
	localparam int unsigned OFF_W   = 7;
	localparam int unsigned SEL_W   = 3;
	localparam int unsigned CNT_W   = 3;

	// Status flag bit positions
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_Z = 1;
	localparam int unsigned FLG_N = 2;
	localparam int unsigned FLG_V = 3;
	localparam int unsigned FLG_S = 4;
	localparam int unsigned FLG_H = 5;

	// Inverting base for the mask-clear operation
	localparam logic [7:0] MASK_ALL = 8'hff;

	// Cycle costs
	localparam logic [2:0] CYC_ONE   = 3'h1;
	localparam logic [2:0] CYC_TWO   = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR  = 3'h4;

	// Counter widths above this make the call one cycle longer
	localparam int unsigned SHORT_PC_W = 16;

	// Operation codes handed in by the fetch stage
	typedef enum logic [4:0] {
		OP_OR_MASK    = 5'h00,
		OP_AND_NOT    = 5'h01,
		OP_SELF_AND   = 5'h02,
		OP_PTR_JUMP   = 5'h03,
		OP_PTR_CALL   = 5'h04,
		OP_EQ_SKIP    = 5'h05,
		OP_RBIT_LOW   = 5'h06,
		OP_RBIT_HIGH  = 5'h07,
		OP_IOBIT_LOW  = 5'h08,
		OP_IOBIT_HIGH = 5'h09,
		OP_BR_FLAG_HI = 5'h0a,
		OP_BR_FLAG_LO = 5'h0b,
		OP_BR_CARRY   = 5'h0c,
		OP_BR_UNEQUAL = 5'h0d,
		OP_BR_MINUS   = 5'h0e,
		OP_BR_PLUS    = 5'h0f,
		OP_BR_SGE     = 5'h10,
		OP_BR_SLT     = 5'h11,
		OP_BR_HC_HI   = 5'h12,
		OP_BR_HC_LO   = 5'h13
	} bse_op_e;

	// Sequencer states
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} bse_state_e;

endpackage : bse_pkg

/* bench/bse_core_model.sv */
`timescale 1ns/1ps
// Far side of the executer: program counter, one register and a return slot
module bse_core_model
	import bse_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_done,
	input  wire logic              i_reg_we,
	input  wire logic [DATA_W-1:0] i_reg_data,
	input  wire logic [PC_W-1:0]   i_next_pc,
	input  wire logic              i_push_we,
	input  wire logic [PC_W-1:0]   i_push_addr,
	output logic [DATA_W-1:0]      o_reg_q,
	output logic [PC_W-1:0]        o_pc_q,
	output logic [PC_W-1:0]        o_stack_q,
	output logic [7:0]             o_wr_cnt
);

	////////////////////////////////////////////////////////////////////////
	// Takes each result only on its strobe; a stray strobe shows up as a
	// changed copy or count, so the bench can see it long afterwards
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_reg_q   <= '0;
			o_pc_q    <= '0;
			o_stack_q <= '0;
			o_wr_cnt  <= '0;
		end
		else
		begin
			if (i_done)
				o_pc_q <= i_next_pc;
			if (i_reg_we)
			begin
				o_reg_q  <= i_reg_data;
				o_wr_cnt <= o_wr_cnt + 8'h01;
			end
			if (i_push_we)
				o_stack_q <= i_push_addr;
		end
	end

endmodule : bse_core_model

/* bench/branch_skip_bitop_exec_tb_top.sv */
`timescale 1ns/1ps
module branch_skip_bitop_exec_tb_top
	import bse_pkg::*;
;
	// Upper counter bits set so a pointer target must clear them
	localparam logic [PC_W-1:0] PC0   = 22'h3f0100;
	localparam int              LIMIT = 2000;

	typedef struct packed {
		bse_op_e     op;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  x;
		logic [2:0]  sel;
		logic [7:0]  status_flags_reg;
		logic [2:0]  cyc;
		logic [21:0] npc;
	} bse_row_s;

	logic              i_clk, i_arst_n, i_start, i_skip_two;
	bse_op_e           i_op;
	logic [PC_W-1:0]   i_pc, o_next_pc, o_push_addr, m_pc, m_stack;
	logic [7:0]        i_rd_val, i_rr_val, i_imm, i_io_val, i_status_flags_reg;
	logic [7:0]        o_reg_data, o_status_flags_reg_data, m_reg, m_cnt;
	logic [2:0]        i_bit_sel;
	logic [OFF_W-1:0]  i_offset;
	logic [PTR_W-1:0]  i_ptr;
	logic              o_ready, o_done, o_reg_we, o_status_flags_reg_we;
	logic              o_pc_load, o_push_we;
	int                num_errors, total_checks, cyc_cnt;

	// x feeds the mask, the offset, the pointer low byte and the long skip
	bse_row_s rows [37] = '{
		'{OP_OR_MASK,8'h80,8'h00,8'h01,3'h0,8'h0f,3'h1,22'h3f0101},
		'{OP_AND_NOT,8'hf0,8'h00,8'hf0,3'h0,8'h20,3'h1,22'h3f0101},
		'{OP_AND_NOT,8'hff,8'h00,8'h0f,3'h0,8'h00,3'h1,22'h3f0101},
		'{OP_SELF_AND,8'h7f,8'h00,8'h00,3'h0,8'h0e,3'h1,22'h3f0101},
		'{OP_SELF_AND,8'h80,8'h00,8'h00,3'h0,8'h00,3'h1,22'h3f0101},
		'{OP_PTR_JUMP,8'hbe,8'h00,8'hef,3'h0,8'h00,3'h2,22'h00beef},
		'{OP_PTR_CALL,8'h12,8'h00,8'h34,3'h0,8'h00,3'h4,22'h001234},
		'{OP_EQ_SKIP,8'h5a,8'h5a,8'h00,3'h0,8'h00,3'h2,22'h3f0102},
		'{OP_EQ_SKIP,8'h5a,8'h5b,8'h80,3'h0,8'h00,3'h1,22'h3f0101},
		'{OP_EQ_SKIP,8'h5a,8'h5a,8'h80,3'h0,8'h00,3'h3,22'h3f0103},
		'{OP_RBIT_LOW,8'h00,8'hf7,8'h00,3'h3,8'h00,3'h2,22'h3f0102},
		'{OP_RBIT_LOW,8'h00,8'h08,8'h00,3'h3,8'h00,3'h1,22'h3f0101},
		'{OP_RBIT_HIGH,8'h00,8'h80,8'h80,3'h7,8'h00,3'h3,22'h3f0103},
		'{OP_RBIT_HIGH,8'h00,8'h7f,8'h80,3'h7,8'h00,3'h1,22'h3f0101},
		'{OP_IOBIT_LOW,8'h00,8'h01,8'h00,3'h0,8'h00,3'h2,22'h3f0102},
		'{OP_IOBIT_HIGH,8'h00,8'hfe,8'h80,3'h0,8'h00,3'h3,22'h3f0103},
		'{OP_IOBIT_HIGH,8'h00,8'h01,8'h80,3'h0,8'h00,3'h1,22'h3f0101},
		'{OP_BR_FLAG_HI,8'h00,8'h00,8'h05,3'h6,8'h40,3'h2,22'h3f0106},
		'{OP_BR_FLAG_HI,8'h00,8'h00,8'h05,3'h6,8'hbf,3'h1,22'h3f0101},
		'{OP_BR_FLAG_LO,8'h00,8'h00,8'h7f,3'h6,8'hbf,3'h2,22'h3f0100},
		'{OP_BR_FLAG_LO,8'h00,8'h00,8'h7f,3'h6,8'h40,3'h1,22'h3f0101},
		'{OP_BR_CARRY,8'h00,8'h00,8'h40,3'h0,8'h01,3'h2,22'h3f00c1},
		'{OP_BR_CARRY,8'h00,8'h00,8'h40,3'h0,8'hfe,3'h1,22'h3f0101},
		'{OP_BR_UNEQUAL,8'h00,8'h00,8'h3f,3'h0,8'hfd,3'h2,22'h3f0140},
		'{OP_BR_UNEQUAL,8'h00,8'h00,8'h3f,3'h0,8'h02,3'h1,22'h3f0101},
		'{OP_BR_MINUS,8'h00,8'h00,8'h02,3'h0,8'h04,3'h2,22'h3f0103},
		'{OP_BR_MINUS,8'h00,8'h00,8'h02,3'h0,8'hfb,3'h1,22'h3f0101},
		'{OP_BR_PLUS,8'h00,8'h00,8'h02,3'h0,8'hfb,3'h2,22'h3f0103},
		'{OP_BR_PLUS,8'h00,8'h00,8'h02,3'h0,8'h04,3'h1,22'h3f0101},
		'{OP_BR_SGE,8'h00,8'h00,8'h02,3'h0,8'h1c,3'h2,22'h3f0103},
		'{OP_BR_SGE,8'h00,8'h00,8'h02,3'h0,8'h14,3'h1,22'h3f0101},
		'{OP_BR_SLT,8'h00,8'h00,8'h02,3'h0,8'h08,3'h2,22'h3f0103},
		'{OP_BR_SLT,8'h00,8'h00,8'h02,3'h0,8'h1c,3'h1,22'h3f0101},
		'{OP_BR_HC_HI,8'h00,8'h00,8'h02,3'h0,8'h20,3'h2,22'h3f0103},
		'{OP_BR_HC_HI,8'h00,8'h00,8'h02,3'h0,8'hdf,3'h1,22'h3f0101},
		'{OP_BR_HC_LO,8'h00,8'h00,8'h02,3'h0,8'hdf,3'h2,22'h3f0103},
		'{OP_BR_HC_LO,8'h00,8'h00,8'h02,3'h0,8'h20,3'h1,22'h3f0101}
	};

	////////////////////////////////////////////////////////////////////////
	bse_exec #(.P_PC_W(PC_W)) DUT (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start),
		.i_op(i_op), .i_pc(i_pc), .i_rd_val(i_rd_val),
		.i_rr_val(i_rr_val), .i_imm(i_imm), .i_io_val(i_io_val),
		.i_bit_sel(i_bit_sel), .i_status_flags_reg(i_status_flags_reg), .i_offset(i_offset),
		.i_ptr(i_ptr), .i_skip_two(i_skip_two), .o_ready(o_ready),
		.o_done(o_done), .o_reg_we(o_reg_we), .o_reg_data(o_reg_data),
		.o_status_flags_reg_we(o_status_flags_reg_we), .o_status_flags_reg_data(o_status_flags_reg_data),
		.o_pc_load(o_pc_load), .o_next_pc(o_next_pc),
		.o_push_we(o_push_we), .o_push_addr(o_push_addr));

	bse_core_model u_model (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_done(o_done),
		.i_reg_we(o_reg_we), .i_reg_data(o_reg_data),
		.i_next_pc(o_next_pc), .i_push_we(o_push_we),
		.i_push_addr(o_push_addr), .o_reg_q(m_reg), .o_pc_q(m_pc),
		.o_stack_q(m_stack), .o_wr_cnt(m_cnt));

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic chk_val(string nm, logic [21:0] e, logic [21:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val

	task automatic chk_bit(string nm, logic e, logic g);
		chk_val(nm, {21'h0, e}, {21'h0, g});
	endtask : chk_bit

	// New flags after a logic op: V cleared, so S follows N
	function automatic logic [7:0] flg(logic [7:0] res, logic [7:0] s);
		flg = s;
		flg[FLG_Z] = (res == 8'h00);
		flg[FLG_N] = res[7];
		flg[FLG_V] = 1'b0;
		flg[FLG_S] = res[7];
	endfunction : flg

	// IO value is the inverse of the second register so a swap shows
	task automatic drive(bse_row_s r);
		i_op       <= r.op;
		i_rd_val   <= r.a;
		i_rr_val   <= r.b;
		i_io_val   <= ~r.b;
		i_imm      <= r.x;
		i_offset   <= r.x[6:0];
		i_ptr      <= {r.a, r.x};
		i_skip_two <= r.x[7];
		i_bit_sel  <= r.sel;
		i_status_flags_reg     <= r.status_flags_reg;
	endtask : drive

	// One request, then count cycles to completion and check its results
	task automatic run(bse_row_s r);
		int         n;
		logic [7:0] res;
		logic       wr;
		@(posedge i_clk);
		drive(r);
		i_start <= 1'b1;
		@(posedge i_clk);
		i_start <= 1'b0;
		n = 1;
		@(negedge i_clk);
		while (o_done !== 1'b1 && n < 8)
		begin
			n++;
			@(negedge i_clk);
		end
		res = (r.op == OP_OR_MASK) ? (r.a | r.x) : (r.a & (MASK_ALL - r.x));
		res = (r.op == OP_SELF_AND) ? r.a : res;
		wr  = (r.op == OP_OR_MASK) || (r.op == OP_AND_NOT);
		chk_val("cycles", {19'h0, r.cyc}, n[21:0]);
		chk_val("next_pc", r.npc, o_next_pc);
		chk_bit("pc_load", r.npc != PC0 + 22'h1, o_pc_load);
		chk_bit("reg_we", wr, o_reg_we);
		chk_bit("status_flags_reg_we", r.op <= OP_SELF_AND, o_status_flags_reg_we);
		chk_bit("push_we", r.op == OP_PTR_CALL, o_push_we);
		if (wr)
			chk_val("reg_data", {14'h0, res}, {14'h0, o_reg_data});
		if (r.op <= OP_SELF_AND)
			chk_val("status_flags_reg", {14'h0, flg(res, r.status_flags_reg)}, {14'h0, o_status_flags_reg_data});
	endtask : run

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Hang guard
	always @(posedge i_clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == LIMIT)
		begin
			num_errors++;
			stop_test();
		end
	end

	initial
	begin
		cyc_cnt  = 0;
		i_arst_n = 1'b0;
		i_start  = 1'b0;
		i_pc     = PC0;
		drive(rows[0]);
		repeat (6) @(negedge i_clk);
		chk_bit("rst_ready", 1'b1, o_ready);
		chk_bit("rst_done", 1'b0, o_done);
		chk_val("rst_pc", 22'h0, o_next_pc);
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		foreach (rows[i])
			run(rows[i]);
		// Model copies land one edge after the done cycle
		@(negedge i_clk);
		chk_val("model_pc", rows[36].npc, m_pc);
		chk_val("model_wr", 22'h3, {14'h0, m_cnt});
		// Call with a second request held during the busy cycles
		@(posedge i_clk);
		drive(rows[6]);
		i_start <= 1'b1;
		@(posedge i_clk);
		drive(rows[0]);
		repeat (3)
		begin
			@(negedge i_clk);
			chk_bit("busy_ready", 1'b0, o_ready);
			chk_bit("busy_done", 1'b0, o_done);
		end
		@(negedge i_clk);
		chk_bit("call_done", 1'b1, o_push_we);
		chk_val("call_push", PC0 + 22'h1, o_push_addr);
		@(posedge i_clk);
		i_start <= 1'b0;
		@(negedge i_clk);
		chk_bit("b2b_done", 1'b1, o_done);
		chk_val("model_push", PC0 + 22'h1, m_stack);
		@(negedge i_clk);
		chk_val("b2b_reg", 22'h81, {14'h0, m_reg});
		chk_val("b2b_wr", 22'h4, {14'h0, m_cnt});
		// Reset in the middle of a call drops it
		@(posedge i_clk);
		drive(rows[6]);
		i_start <= 1'b1;
		@(posedge i_clk);
		i_start  <= 1'b0;
		i_arst_n <= 1'b0;
		@(negedge i_clk);
		chk_bit("mid_ready", 1'b1, o_ready);
		chk_bit("mid_push", 1'b0, o_push_we);
		@(posedge i_clk);
		i_arst_n <= 1'b1;
		run(rows[1]);
		stop_test();
	end

endmodule : branch_skip_bitop_exec_tb_top
